// [include/pmc_pkg.sv]
// Shared constants and types for the power reduction controller and its CPU side
package pmc_pkg;

   // ---------------------------------------------------------------
   // System control register layout
   // ---------------------------------------------------------------
   localparam int          CTL_W      = 5;
   localparam int          CTL_PWRDN  = 0;  // powerdown_request_bit
   localparam int          CTL_HALT   = 1;  // cpu_halt_low_power_bit
   localparam int          CTL_SLOW   = 2;  // slow_clock_bit
   localparam int          CTL_NODLY  = 3;  // wake_delay_disable_bit
   localparam int          CTL_PULLUP = 4;  // bus_pullup_enable_bit
   localparam logic [4:0]  CTL_RESET  = 5'h00;

   // ---------------------------------------------------------------
   // Clocking and wake-up timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          IDLE_DIV       = 512;
   localparam int          DIV_W          = 9;
   localparam int          WAKE_DELAY_CYC = 1536;
   localparam int          WAKE_W         = 11;

   // ---------------------------------------------------------------
   // Interrupt pins and levels
   // ---------------------------------------------------------------
   localparam int          PIN_N     = 8;   // seven maskable plus the non-maskable
   localparam int          NMI_IDX   = 7;
   localparam int          PRIO_W    = 21;  // 3 bits for each maskable pin
   localparam logic [2:0]  LVL_MAX   = 3'h7;
   localparam logic [20:0] PRIO_RESET = 21'h000000;
   localparam logic [7:0]  SEL_RESET  = 8'h00;

   // ---------------------------------------------------------------
   // Wishbone register map of the CPU side (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_STATUS = 8'h04;
   localparam logic [7:0]  ADR_CMD    = 8'h08;
   localparam logic [7:0]  ADR_PINSEL = 8'h0c;
   localparam logic [7:0]  ADR_PRIO   = 8'h10;
   localparam int          CMD_STOP   = 0;
   localparam int          CMD_ACK    = 1;

   // ---------------------------------------------------------------
   // Controller states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RUN       = 5'h01,
      ST_STOPPED   = 5'h02,
      ST_STANDBY   = 5'h04,
      ST_POWERDOWN = 5'h08,
      ST_WAKEDELAY = 5'h10
   } pmc_state_t;

   // Selected interrupt pins that are currently low
   function automatic logic [7:0] pmc_active_pins(input logic [7:0] sel,
                                                  input logic [7:0] pinsN);
      return sel & ~pinsN;
   endfunction

endpackage

// [include/pmc_if.sv]
// Link between the power reduction controller and the CPU side
`timescale 1ns/1ps
interface pmc_if;
   import pmc_pkg::*;

   logic             ctlWe;        // write strobe for system control register
   logic [4:0]       ctlWdata;     // value written
   logic [4:0]       ctlRdata;     // current system control register
   logic             stopCmd;      // stop instruction executed, one cycle
   logic             intAck;       // interrupt acknowledge, one cycle
   logic             irqInternal;  // any on-chip interrupt activated
   logic [7:0]       pinSelect;    // interrupt_pin_select_bit per pin
   logic [20:0]      intPrio;      // interrupt_priority_field per maskable pin
   logic [4:0]       devState;     // controller state code
   logic             cpuClkEn;     // CPU clock enable
   logic             wakeIrq;      // wake-up interrupt request
   logic [2:0]       wakeLevel;    // level of that request

   modport dev (
      input  ctlWe, ctlWdata, stopCmd, intAck, irqInternal, pinSelect, intPrio,
      output ctlRdata, devState, cpuClkEn, wakeIrq, wakeLevel
   );
   modport cpu (
      output ctlWe, ctlWdata, stopCmd, intAck, irqInternal, pinSelect, intPrio,
      input  ctlRdata, devState, cpuClkEn, wakeIrq, wakeLevel
   );
endinterface

// [hw/pmc_power_ctrl.sv]
// Power reduction controller: power-down, standby and idle clock control
//
// Behaviour
// [RL1] Three modes: power-down, standby, divide-by-512 idle
// [RL2] Power-down only by bit then stop
// [RL3] Registers hold unchanged through power-down
// [RL4] Leave power-down on reset or low pin
// [RL5] Interrupt wake-up first gives a level-7 interrupt
// [RL6] Waking pin at priority 7 repeats level 7
// [RL7] Waking pin must be low and selected
// [RL8] Without delay-disable, wait 1536 cycles after wake
// [RL9] Power-down bit clears itself on wake-up
// [RL10] Delay-disable bit restarts clocks immediately
// [RL11] Pull-up bit enables bus pull-ups
// [RL12] External reset held until oscillator stable
// [RL13] Standby stops only the CPU clock
// [RL14] Any interrupt restarts CPU from standby
// [RL15] Idle bit divides clock by 512 at once
// [RL16] Clearing idle bit restores full clock
// [RL17] Idle divided clock drives peripherals too
// [RL18] Power-down from idle resumes in idle
// [RL19] Software turns pull-ups off when unneeded
// [RL20] After stop, CPU makes no memory references
// [RL21] Interrupt pins act only when selected
// [RL22] Non-maskable input always has level 7
// [RL23] Stop without power-down bit only stops CPU
// [RL24] Control bits read-write, cleared by reset
`timescale 1ns/1ps
module pmc_power_ctrl
   import pmc_pkg::*;
(
   input  wire logic       clk_sys,     // 50 MHz system clock
   input  wire logic       rst,         // synchronous reset, active high
   input  wire logic       intRstReq,   // on-chip reset request, same clock
   input  wire logic [6:0] intPinN,     // maskable_interrupt_inputs, active low
   input  wire logic       nmiPinN,     // nonmaskable_interrupt_input, active low
   pmc_if.dev              link,        // CPU side
   output logic            oscEn,       // oscillator running
   output logic            periphClkEn, // peripheral clock enable
   output logic            pullupEn     // bus pull-ups on
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [7:0]  pinMeta;
   logic [7:0]  pinSync;
   logic [7:0]  activeLow;
   logic [7:0]  prevActive;
   logic [7:0]  fallEdge;
   logic        resetAll;

   assign resetAll = rst | intRstReq;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pinMeta <= 8'hff;
         pinSync <= 8'hff;
      end else begin
         pinMeta <= {nmiPinN, intPinN};
         pinSync <= pinMeta;
      end
   end

   // Unselected pins are port pins and never reach wake logic
   assign activeLow = pmc_active_pins(link.pinSelect, pinSync); // [RL21] [RL7]

   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         prevActive <= 8'h00;
      end else begin
         prevActive <= activeLow;
      end
   end

   assign fallEdge = activeLow & ~prevActive;

   // ---------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------
   pmc_state_t               state;
   pmc_state_t               next_state;
   logic [4:0]               ctl;
   logic [WAKE_W-1:0]        delayCnt;
   logic                     delayDone;
   logic                     anyEvent;
   logic                     wakeNow;

   assign delayDone = (delayCnt == WAKE_W'(WAKE_DELAY_CYC - 1));
   assign anyEvent  = (|fallEdge) | link.irqInternal;
   assign wakeNow   = (state == ST_POWERDOWN) && (|activeLow); // [RL4]

   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (link.stopCmd && ctl[CTL_PWRDN]) begin
               next_state = ST_POWERDOWN; // [RL2]
            end else if (link.stopCmd) begin
               next_state = ST_STOPPED; // [RL23] [RL20]
            end else if (ctl[CTL_HALT]) begin
               next_state = ST_STANDBY; // [RL13]
            end
         end
         ST_STOPPED: begin
            if (anyEvent) begin
               next_state = ST_RUN;
            end
         end
         ST_STANDBY: begin
            if (anyEvent) begin
               next_state = ST_RUN; // [RL14]
            end
         end
         ST_POWERDOWN: begin
            if (wakeNow && ctl[CTL_NODLY]) begin
               next_state = ST_RUN; // [RL10]
            end else if (wakeNow) begin
               next_state = ST_WAKEDELAY; // [RL8]
            end
         end
         ST_WAKEDELAY: begin
            if (delayDone) begin
               next_state = ST_RUN; // [RL8]
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // Internal reset also ends power-down, as it resets all here but the pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         state <= ST_RUN; // [RL4]
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Oscillator stabilisation counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (resetAll || state != ST_WAKEDELAY) begin
         delayCnt <= '0;
      end else begin
         delayCnt <= delayCnt + WAKE_W'(1); // [RL8]
      end
   end

   // ---------------------------------------------------------------
   // System control register
   // ---------------------------------------------------------------
   // Writes only land while the CPU runs; a halted CPU cannot issue
   // them, and refusing them keeps contents frozen in power-down.
   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         ctl <= CTL_RESET; // [RL24]
      end else begin
         if (link.ctlWe && state == ST_RUN) begin
            ctl <= link.ctlWdata; // [RL24] [RL3]
         end
         if (wakeNow) begin
            ctl[CTL_PWRDN] <= 1'b0; // [RL9]
         end
         if (state == ST_STANDBY && anyEvent) begin
            ctl[CTL_HALT] <= 1'b0; // [RL14]
         end
      end
   end

   assign link.ctlRdata = ctl;
   assign link.devState = state;

   // ---------------------------------------------------------------
   // Idle divider
   // ---------------------------------------------------------------
   // Frozen with the oscillator, so idle survives a power-down cycle.
   logic [DIV_W-1:0]  divCnt;
   logic              divTick;
   logic              clkTick;

   always_ff @(posedge clk_sys) begin
      if (resetAll || !ctl[CTL_SLOW]) begin
         divCnt <= '0; // [RL16]
      end else if (state != ST_POWERDOWN) begin
         divCnt <= divCnt + DIV_W'(1); // [RL18]
      end
   end

   assign divTick = (divCnt == DIV_W'(IDLE_DIV - 1)); // [RL1]
   // Takes effect on the very next cycle, no resync of the divider
   assign clkTick = ctl[CTL_SLOW] ? divTick : 1'b1; // [RL15] [RL16]

   // ---------------------------------------------------------------
   // Clock enables and pull-ups
   // ---------------------------------------------------------------
   assign oscEn         = (state != ST_POWERDOWN); // [RL1] [RL2]
   assign link.cpuClkEn = (state == ST_RUN) && clkTick; // [RL13] [RL20]
   // Peripherals stay clocked in standby and stop, but share the
   // divided clock in idle, so serial and converter timing breaks.
   assign periphClkEn   = (state != ST_POWERDOWN) && (state != ST_WAKEDELAY)
                          && clkTick; // [RL13] [RL17] [RL23]

   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         pullupEn <= 1'b0;
      end else begin
         pullupEn <= ctl[CTL_PULLUP]; // [RL11]
      end
   end

   // ---------------------------------------------------------------
   // Wake-up interrupt sequencing
   // ---------------------------------------------------------------
   logic [2:0]  wakePin;
   logic [2:0]  wakePinPrio;
   logic        wakePend;
   logic        wakeRepeat;

   // Highest-numbered active pin wins, the non-maskable one first
   function automatic logic [2:0] pmc_top_pin(input logic [7:0] act);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 0; i < PIN_N; i++) begin
         if (act[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   assign wakePinPrio = (wakePin == 3'(NMI_IDX)) ? LVL_MAX
                        : link.intPrio[wakePin*3 +: 3]; // [RL22]

   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         wakePin <= 3'h0;
      end else if (wakeNow) begin
         wakePin <= pmc_top_pin(activeLow);
      end
   end

   // Set only in power-down, cleared only by acknowledge while running,
   // so the two can never meet in one cycle.
   always_ff @(posedge clk_sys) begin
      if (resetAll) begin
         wakePend   <= 1'b0;
         wakeRepeat <= 1'b0;
      end else if (wakeNow) begin
         wakePend   <= 1'b1; // [RL5]
         wakeRepeat <= 1'b0;
      end else if (link.intAck && wakePend && state == ST_RUN) begin
         if (!wakeRepeat && wakePinPrio == LVL_MAX) begin
            wakeRepeat <= 1'b1; // [RL6]
         end else begin
            wakePend   <= 1'b0;
            wakeRepeat <= 1'b0;
         end
      end
   end

   assign link.wakeIrq   = wakePend && (state == ST_RUN); // [RL5]
   assign link.wakeLevel = LVL_MAX; // [RL5] [RL6]

endmodule

// [hw/pmc_cpu_side.sv]
// CPU side of the power controller: Wishbone register block driving the link
`timescale 1ns/1ps
module pmc_cpu_side
   import pmc_pkg::*;
(
   input  wire logic        clk_sys,     // 50 MHz system clock
   input  wire logic        rst,         // synchronous reset, active high
   input  wire logic        wbCyc,       // Wishbone cycle
   input  wire logic        wbStb,       // Wishbone strobe
   input  wire logic        wbWe,        // Wishbone write enable
   input  wire logic [7:0]  wbAdr,       // Wishbone byte address
   input  wire logic [3:0]  wbSel,       // Wishbone byte selects
   input  wire logic [31:0] wbDatW,      // Wishbone write data
   output logic      [31:0] wbDatR,      // Wishbone read data
   output logic             wbAck,       // Wishbone acknowledge
   input  wire logic        onChipIrq,   // any on-chip interrupt active
   pmc_if.cpu               link         // power controller
);

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   logic  acc;
   logic  wrAcc;

   assign acc   = wbCyc && wbStb && !wbAck;
   assign wrAcc = acc && wbWe;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wbAck <= 1'b0;
      end else begin
         wbAck <= acc;
      end
   end

   // ---------------------------------------------------------------
   // Local registers
   // ---------------------------------------------------------------
   logic [7:0]  pinSel;
   logic [20:0] prio;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pinSel <= SEL_RESET;
      end else if (wrAcc && wbAdr == ADR_PINSEL && wbSel[0]) begin
         pinSel <= wbDatW[7:0]; // [RL7]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prio <= PRIO_RESET;
      end else if (wrAcc && wbAdr == ADR_PRIO) begin
         if (wbSel[0]) begin
            prio[7:0] <= wbDatW[7:0];
         end
         if (wbSel[1]) begin
            prio[15:8] <= wbDatW[15:8];
         end
         if (wbSel[2]) begin
            prio[20:16] <= wbDatW[20:16]; // [RL6]
         end
      end
   end

   assign link.pinSelect   = pinSel;
   assign link.intPrio     = prio;
   assign link.irqInternal = onChipIrq;

   // ---------------------------------------------------------------
   // Strobes towards the controller
   // ---------------------------------------------------------------
   // Stop is only ever a software command; the power-down path also
   // needs the control bit already set in the controller.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         link.ctlWe    <= 1'b0;
         link.ctlWdata <= CTL_RESET;
         link.stopCmd  <= 1'b0;
         link.intAck   <= 1'b0;
      end else begin
         link.ctlWe   <= wrAcc && wbAdr == ADR_CTRL && wbSel[0]; // [RL16] [RL19]
         link.stopCmd <= wrAcc && wbAdr == ADR_CMD && wbSel[0]
                         && wbDatW[CMD_STOP]; // [RL2]
         link.intAck  <= wrAcc && wbAdr == ADR_CMD && wbSel[0]
                         && wbDatW[CMD_ACK];
         if (wrAcc && wbAdr == ADR_CTRL) begin
            link.ctlWdata <= wbDatW[4:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wbDatR <= 32'h00000000;
      end else if (acc && !wbWe) begin
         unique case (wbAdr)
            ADR_CTRL:   wbDatR <= {27'h0000000, link.ctlRdata};
            ADR_STATUS: wbDatR <= {22'h000000, link.wakeLevel, link.wakeIrq,
                                   link.cpuClkEn, link.devState};
            ADR_PINSEL: wbDatR <= {24'h000000, pinSel};
            ADR_PRIO:   wbDatR <= {11'h000, prio};
            default:    wbDatR <= 32'h00000000;
         endcase
      end
   end

endmodule

// [bench/pmc_assertions.sv]
// Concurrent checks on the link between the power controller and its CPU side
`timescale 1ns/1ps
module pmc_checker
   import pmc_pkg::*;
(
   input wire logic       clk_sys,     // system clock
   input wire logic       rst,         // synchronous reset
   input wire logic       stopCmd,     // stop instruction pulse
   input wire logic       irqInternal, // on-chip interrupt level
   input wire logic [4:0] ctlRdata,    // control register contents
   input wire logic [4:0] devState,    // controller state code
   input wire logic       cpuClkEn,    // CPU clock enable
   input wire logic       wakeIrq,     // wake-up request
   input wire logic [2:0] wakeLevel    // wake-up level
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [10:0] dlyCnt;

   // ------------------------------------------------------------
   // Wake delay counter, too long for a repetition
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst || devState != ST_WAKEDELAY)
         dlyCnt <= 11'h000;
      else
         dlyCnt <= dlyCnt + 11'h001;
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ctl_reset_a: assert property ($fell(rst) |-> ctlRdata == CTL_RESET)
      else $error("control register not clear after reset");
   pwr_entry_a: assert property (devState == ST_RUN && stopCmd && ctlRdata[CTL_PWRDN]
      |=> devState == ST_POWERDOWN) else $error("stop with power-down bit missed");
   stop_only_a: assert property (devState == ST_RUN && stopCmd && !ctlRdata[CTL_PWRDN]
      |=> devState == ST_STOPPED) else $error("plain stop did not stop the CPU");
   pwr_retain_a: assert property (devState == ST_POWERDOWN
      && $past(devState) == ST_POWERDOWN |-> $stable(ctlRdata))
      else $error("control register changed in power-down");
   wake_delay_a: assert property ($fell(devState == ST_WAKEDELAY)
      |-> devState == ST_RUN && $past(dlyCnt) == WAKE_DELAY_CYC - 1)
      else $error("wake delay length wrong");
   wake_irq_a: assert property ($fell(devState == ST_WAKEDELAY)
      |-> ##[0:2] (wakeIrq && wakeLevel == LVL_MAX)) else $error("no level 7 wake request");
   fast_wake_a: assert property (devState == ST_POWERDOWN && ctlRdata[CTL_NODLY]
      |=> devState != ST_WAKEDELAY) else $error("delay not bypassed");
   pwr_clear_a: assert property ($fell(devState == ST_POWERDOWN)
      |-> ##[0:1] !ctlRdata[CTL_PWRDN]) else $error("power-down bit not cleared");
   cpu_gate_a: assert property (devState != ST_RUN |-> !cpuClkEn)
      else $error("CPU clock running while halted");
   standby_exit_a: assert property (devState == ST_STANDBY && irqInternal
      |-> ##[1:3] devState == ST_RUN) else $error("standby not left on interrupt");
   idle_rate_a: assert property (cpuClkEn && ctlRdata[CTL_SLOW]
      |=> (!cpuClkEn || !ctlRdata[CTL_SLOW])[*8]) else $error("idle clock too fast");

   cover property ($fell(devState == ST_WAKEDELAY));
   cover property ($rose(devState == ST_STANDBY));
   cover property ($rose(devState == ST_POWERDOWN) && ctlRdata[CTL_SLOW]);
endmodule

// [bench/power_reduction_mode_control_test.sv]
// Self-checking bench joining the power controller and its CPU side
`timescale 1ns/1ps
module power_reduction_mode_control_test;
   import pmc_pkg::*;
   logic        clk_sys   = 1'b0;
   logic        rst       = 1'b1;
   logic        intRstReq = 1'b0;
   logic [6:0]  intPinN   = 7'h7f;
   logic        nmiPinN   = 1'b1;
   logic        wbCyc     = 1'b0;
   logic        wbStb     = 1'b0;
   logic        wbWe      = 1'b0;
   logic [7:0]  wbAdr     = 8'h00;
   logic [3:0]  wbSel     = 4'h0;
   logic [31:0] wbDatW    = 32'h0;
   logic        onChipIrq = 1'b0;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic        oscEn;
   logic        periphClkEn;
   logic        pullupEn;
   logic [31:0] rdat;
   int          errors     = 0;
   int          num_checks = 0;

   pmc_if i_pmc_if ();
   pmc_power_ctrl i_pmc_power_ctrl (.clk_sys(clk_sys), .rst(rst), .intRstReq(intRstReq),
      .intPinN(intPinN), .nmiPinN(nmiPinN), .link(i_pmc_if.dev), .oscEn(oscEn),
      .periphClkEn(periphClkEn), .pullupEn(pullupEn));
   pmc_cpu_side i_pmc_cpu_side (.clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
      .wbAck(wbAck), .onChipIrq(onChipIrq), .link(i_pmc_if.cpu));
   pmc_checker i_pmc_checker (.clk_sys(clk_sys), .rst(rst), .stopCmd(i_pmc_if.stopCmd),
      .irqInternal(i_pmc_if.irqInternal), .ctlRdata(i_pmc_if.ctlRdata),
      .devState(i_pmc_if.devState), .cpuClkEn(i_pmc_if.cpuClkEn),
      .wakeIrq(i_pmc_if.wakeIrq), .wakeLevel(i_pmc_if.wakeLevel));

   always #10 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      if (errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic single cycle; ack is sampled at the edge, never assumed
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbSel  <= 4'hf;
      wbDatW <= dat;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      chk("ack", 32'h1, {31'h0, wbAck});
      if (wbAck !== 1'b1)
         tally_and_finish();
      rdat = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
      wb(1'b0, adr, 32'h0);
      chk(what, exp, rdat);
   endtask

   task automatic wait_st(input logic [4:0] s, input int max);
      int n;
      n = 0;
      while (i_pmc_if.devState !== s && n < max) begin
         @(posedge clk_sys);
         n++;
      end
      chk("state", {27'h0, s}, {27'h0, i_pmc_if.devState});
      if (i_pmc_if.devState !== s)
         tally_and_finish();
   endtask

   task automatic setpin(input int idx, input logic val);
      if (idx == 7)
         nmiPinN <= val;
      else
         intPinN[idx] <= val;
   endtask

   // Level-7 wake-ups, by the non-maskable pin or priority 7, need two acks
   function automatic int exp_acks(input int pin, input int lvl);
      return (pin == NMI_IDX || lvl == int'(LVL_MAX)) ? 2 : 1;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [4:0] v;
      int         p;
      int         lv;
      int         acks;
      int         n;
      n = $urandom(32'hb1b9);
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(ADR_CTRL, 32'h0, "ctrl");
      wr(8'h14, 32'hffffffff);
      rd(8'h14, 32'h0, "unmapped");
      repeat (4) begin
         v = 5'($urandom) & 5'h18;
         wr(ADR_CTRL, {27'h0, v});
         rd(ADR_CTRL, {27'h0, v}, "ctrl");
         chk("pullup", {31'h0, v[CTL_PULLUP]}, {31'h0, pullupEn});
      end
      wr(ADR_CTRL, 32'h0);
      // Pull-up enable lags the register by one cycle
      @(posedge clk_sys);
      chk("pullup", 32'h0, {31'h0, pullupEn});
      // Idle divider period seen on the peripheral enable
      wr(ADR_CTRL, 32'h4);
      n = 0;
      while (periphClkEn !== 1'b1 && n < 600) begin
         @(posedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
      n = 1;
      while (periphClkEn !== 1'b1 && n < 600) begin
         @(posedge clk_sys);
         n++;
      end
      chk("idle period", 32'(IDLE_DIV), 32'(n));
      wr(ADR_CTRL, 32'h0);
      repeat (2) begin
         @(posedge clk_sys);
         chk("full clock", 32'h1, {31'h0, periphClkEn});
      end
      wr(ADR_CTRL, 32'h2);
      wait_st(ST_STANDBY, 10);
      chk("osc in standby", 32'h1, {31'h0, oscEn & periphClkEn});
      onChipIrq <= 1'b1;
      wait_st(ST_RUN, 10);
      onChipIrq <= 1'b0;
      rd(ADR_CTRL, 32'h0, "halt bit");
      wr(ADR_PINSEL, 32'h1);
      wr(ADR_CMD, 32'h1);
      wait_st(ST_STOPPED, 10);
      chk("osc when stopped", 32'h1, {31'h0, oscEn});
      setpin(0, 1'b0);
      wait_st(ST_RUN, 10);
      setpin(0, 1'b1);
      // Power-down cases: delay on/off, idle on/off, pin and level
      for (int k = 0; k < 4; k++) begin
         p = (k == 1) ? 7 : $urandom_range(6);
         lv = (k == 2) ? 7 : (k == 0) ? 0 : $urandom_range(6);
         acks = exp_acks(p, lv);
         v = {k[1], k == 1 || k == 2, k[0], 2'b01};
         wr(ADR_PINSEL, 32'(1 << p));
         wr(ADR_PRIO, 32'(lv) << (3 * p));
         wr(ADR_CTRL, {27'h0, v});
         wr(ADR_CMD, 32'h1);
         wait_st(ST_POWERDOWN, 10);
         chk("osc off", 32'h0, {31'h0, oscEn});
         wr(ADR_CTRL, 32'h0);
         rd(ADR_CTRL, {27'h0, v}, "ctrl held");
         setpin((p + 1) % 8, 1'b0);
         repeat (6) @(posedge clk_sys);
         chk("unselected pin", {27'h0, ST_POWERDOWN}, {27'h0, i_pmc_if.devState});
         setpin((p + 1) % 8, 1'b1);
         repeat (4) @(posedge clk_sys);
         setpin(p, 1'b0);
         if (v[CTL_NODLY] == 1'b0)
            wait_st(ST_WAKEDELAY, 10);
         wait_st(ST_RUN, v[CTL_NODLY] ? 8 : 1560);
         setpin(p, 1'b1);
         rd(ADR_CTRL, {27'h0, v & 5'h1e}, "powerdown bit");
         wb(1'b0, ADR_STATUS, 32'h0);
         chk("wake irq", 32'hf, {28'h0, rdat[9:6]});
         wr(ADR_CMD, 32'h2);
         wb(1'b0, ADR_STATUS, 32'h0);
         chk("second wake irq", {31'h0, acks == 2}, {31'h0, rdat[6]});
         wr(ADR_CMD, 32'h2);
         wr(ADR_CTRL, 32'h0);
      end
      wr(ADR_CTRL, 32'h1);
      wr(ADR_CMD, 32'h1);
      wait_st(ST_POWERDOWN, 10);
      intRstReq <= 1'b1;
      @(posedge clk_sys);
      intRstReq <= 1'b0;
      wait_st(ST_RUN, 10);
      rd(ADR_CTRL, 32'h0, "ctrl after internal reset");
      // External reset ends power-down; it stays on until the oscillator runs
      wr(ADR_CTRL, 32'h1);
      wr(ADR_CMD, 32'h1);
      wait_st(ST_POWERDOWN, 10);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("osc before reset release", 32'h1, {31'h0, oscEn});
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(ADR_CTRL, 32'h0, "ctrl after external reset");
      tally_and_finish();
   end
endmodule
